// [hdl/adcs_defines.svh]
/*
 Register offsets, field positions, reset values and timing counts of the
 converter sequencer. Assumes inclusion by bare name from the design files.
*/
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ADCS_OFS_MODE0 8'h00
`define ADCS_OFS_MODE1 8'h04
`define ADCS_OFS_MODE2 8'h08
`define ADCS_OFS_RES_BASE 8'h10
`define ADCS_OFS_RES_END 8'h38

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ADCS_M0_START 0
`define ADCS_M0_SCAN 1
`define ADCS_M0_REPEAT 2
`define ADCS_M0_ITM 3
`define ADCS_M0_BUSY 6
`define ADCS_M0_EOC 7
`define ADCS_M1_CH_LSB 0
`define ADCS_M1_I2RUN 5
`define ADCS_M2_TRIG_EN 0

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define ADCS_RST_CH 3'h0
`define ADCS_MAX_CH 3'h4
`define ADCS_ROT_LAST 2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ADCS_CLK_NS 50
`define ADCS_CONV_STATES 132
`define ADCS_CONV_LAST 8'(`ADCS_CONV_STATES - 1)

`endif

// [hdl/adcs_pkg.sv]
/*
 Types shared by the converter sequencer. Assumes nothing of its surroundings.
*/
package adcs_pkg;
    typedef enum logic [1:0] {
        ADCS_IDLE,
        ADCS_CONV,
        ADCS_HOLD
    } adcs_state_e;
    typedef logic [9:0] adcs_result_t;
endpackage

// [hdl/adcs_ctrl.sv]
/*
 Sequencer for a five-input 10-bit successive-approximation converter with
 an APB register port. Assumes an analog core that holds a valid result on
 core_result_in in the last cycle of each 132-cycle conversion, and halt
 inputs that are synchronous to clk_in.
*/
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "adcs_defines.svh"

module adcs_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Trigger pin and halt states
    input wire logic ext_trigger_pin_in,
    input wire logic halt_stop_in,
    input wire logic halt_idle_one_in,
    input wire logic halt_idle_two_in,
    // Analog core
    input wire adcs_pkg::adcs_result_t core_result_in,
    output logic core_start_out,
    output logic core_active_out,
    output logic [2:0] core_channel_out,
    // Completion interrupt
    output logic conv_end_irq_out
);
    import adcs_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    adcs_state_e state;
    adcs_state_e next_state;
    logic [7:0] cnt;
    logic [1:0] rot;
    logic trig_prev;
    logic scan_bit;
    logic repeat_bit;
    logic irq_timing_bit;
    logic conv_end_flag;
    logic [2:0] channel_select_field;
    logic idle_two_run_bit;
    logic ext_trigger_enable;
    adcs_result_t res_val [0:4];
    logic [4:0] result_stored_flag;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire acc = psel_in & penable_in & pready_out;
    wire wr = acc & pwrite_in;
    wire rd = acc & ~pwrite_in;
    wire sel_m0 = paddr_in == `ADCS_OFS_MODE0;
    wire sel_m1 = paddr_in == `ADCS_OFS_MODE1;
    wire sel_m2 = paddr_in == `ADCS_OFS_MODE2;
    wire [7:0] roff = paddr_in - `ADCS_OFS_RES_BASE;
    wire res_hit = (paddr_in >= `ADCS_OFS_RES_BASE) && (paddr_in < `ADCS_OFS_RES_END)
        && (paddr_in[1:0] == 2'h0);
    wire [2:0] rd_idx = roff[5:3];
    wire rd_hi = roff[2];
    wire hit = sel_m0 | sel_m1 | sel_m2 | res_hit;
    wire rd_res = rd & res_hit;

    // ------------------------------------------------------------------
    // Sequencing terms
    // ------------------------------------------------------------------
    wire conv_busy_flag = state != ADCS_IDLE;
    wire halt = halt_stop_in | halt_idle_one_in | (halt_idle_two_in & ~idle_two_run_bit);
    wire trig_fall = trig_prev & ~ext_trigger_pin_in;
    wire sw_start_bit = wr & sel_m0 & pwdata_in[`ADCS_M0_START];
    wire start_req = ~conv_busy_flag & ~halt
        & (sw_start_bit | (ext_trigger_enable & trig_fall));
    wire [2:0] last_ch = (channel_select_field > `ADCS_MAX_CH) ? `ADCS_MAX_CH
        : channel_select_field;
    wire done = (state == ADCS_CONV) && (cnt == `ADCS_CONV_LAST) && !halt;
    wire scan_end = scan_bit & (core_channel_out == last_ch);
    wire fix_rep = repeat_bit & ~scan_bit;
    wire rot_mode = fix_rep & irq_timing_bit;
    wire [2:0] store_idx = rot_mode ? {1'b0, rot} : core_channel_out;
    wire group_end = done & (~scan_bit | scan_end);
    wire irq_ev = group_end & ~(rot_mode & (rot != `ADCS_ROT_LAST));
    wire go_on = scan_bit ? (~scan_end | repeat_bit) : repeat_bit;
    wire [2:0] next_ch = scan_bit ? (scan_end ? 3'h0 : core_channel_out + 3'h1) : last_ch;
    // A start written together with new mode bits must use those bits, or a scan
    // would begin on the channel of the previous mode.
    wire scan_now = (wr && sel_m0) ? pwdata_in[`ADCS_M0_SCAN] : scan_bit;
    wire entering = (state != ADCS_CONV) && (next_state == ADCS_CONV);

    always_comb begin
        next_state = state;
        case (state)
            ADCS_IDLE: begin
                if (start_req) begin
                    next_state = ADCS_CONV;
                end
            end
            ADCS_CONV: begin
                if (halt) begin
                    next_state = repeat_bit ? ADCS_HOLD : ADCS_IDLE;
                end else if (done && !go_on) begin
                    next_state = ADCS_IDLE;
                end
            end
            ADCS_HOLD: begin
                if (!repeat_bit) begin
                    next_state = ADCS_IDLE;
                end else if (!halt) begin
                    next_state = ADCS_CONV;
                end
            end
            default: begin
                next_state = ADCS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------------
    // Starts are only taken while idle; a start during a conversion would
    // otherwise tear a scan in half without the software seeing it.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= ADCS_IDLE;
            cnt <= 8'h00;
            rot <= 2'h0;
            trig_prev <= 1'b1;
            core_start_out <= 1'b0;
            core_active_out <= 1'b0;
            core_channel_out <= `ADCS_RST_CH;
            conv_end_irq_out <= 1'b0;
        end else begin
            state <= next_state;
            trig_prev <= ext_trigger_pin_in;
            cnt <= (state == ADCS_CONV && next_state == ADCS_CONV && !done) ? cnt + 8'h01
                : 8'h00;
            core_start_out <= (next_state == ADCS_CONV) && (entering || done);
            core_active_out <= next_state == ADCS_CONV;
            conv_end_irq_out <= irq_ev;
            if (entering) begin
                core_channel_out <= scan_now ? 3'h0 : last_ch;
                rot <= 2'h0;
            end else if (done) begin
                core_channel_out <= next_ch;
                rot <= rot_mode ? rot + 2'h1 : 2'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scan_bit <= 1'b0;
            repeat_bit <= 1'b0;
            irq_timing_bit <= 1'b0;
            conv_end_flag <= 1'b0;
            channel_select_field <= `ADCS_RST_CH;
            idle_two_run_bit <= 1'b0;
            ext_trigger_enable <= 1'b0;
        end else begin
            if (wr && sel_m0) begin
                scan_bit <= pwdata_in[`ADCS_M0_SCAN];
                repeat_bit <= pwdata_in[`ADCS_M0_REPEAT];
                irq_timing_bit <= pwdata_in[`ADCS_M0_ITM];
            end
            if (wr && sel_m1) begin
                channel_select_field <= pwdata_in[`ADCS_M1_CH_LSB +: 3];
                idle_two_run_bit <= pwdata_in[`ADCS_M1_I2RUN];
            end
            if (wr && sel_m2) begin
                ext_trigger_enable <= pwdata_in[`ADCS_M2_TRIG_EN];
            end
            if (group_end || (done && fix_rep)) begin
                conv_end_flag <= 1'b1;
            end else if (rd_res) begin
                conv_end_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Result store
    // ------------------------------------------------------------------
    // Results hold no reset value; only the stored flags are cleared.
    always_ff @(posedge clk_in) begin
        if (done) begin
            res_val[store_idx] <= core_result_in;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_flag
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    result_stored_flag[gi] <= 1'b0;
                end else if (done && store_idx == 3'(gi)) begin
                    result_stored_flag[gi] <= 1'b1;
                end else if (rd_res && rd_idx == 3'(gi)) begin
                    result_stored_flag[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire [7:0] m0_rd = {conv_end_flag, conv_busy_flag, 2'h0, irq_timing_bit, repeat_bit,
        scan_bit, 1'b0};
    wire [7:0] m1_rd = {2'h0, idle_two_run_bit, 2'h0, channel_select_field};
    wire [2:0] safe_idx = (rd_idx > `ADCS_MAX_CH) ? `ADCS_MAX_CH : rd_idx;
    wire adcs_result_t sel_res = res_val[safe_idx];
    wire [7:0] res_rd = rd_hi ? sel_res[9:2]
        : {sel_res[1:0], 5'h00, result_stored_flag[safe_idx]};
    wire [7:0] rd_byte = sel_m0 ? m0_rd : sel_m1 ? m1_rd
        : sel_m2 ? {7'h00, ext_trigger_enable} : res_hit ? res_rd : 8'h00;

    // One wait state: read data is captured, then presented with pready.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in & penable_in & ~pready_out;
            prdata_out <= (psel_in && penable_in && !pready_out) ? {24'h00_0000, rd_byte}
                : 32'h0000_0000;
            pslverr_out <= psel_in & penable_in & ~pready_out & ~hit;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_BUSY_ON_START: assert property (start_req |=> conv_busy_flag && core_start_out)
        else $error("busy or core start missing after start request");
    AST_TRIG_IGNORED: assert property ((state == ADCS_CONV) && trig_fall && !halt && !done
        |=> cnt == $past(cnt) + 8'h01)
        else $error("trigger edge disturbed a running conversion");
    AST_CONV_LEN: assert property (done |-> $past(core_start_out, 131))
        else $error("conversion did not last 132 cycles");
    AST_FIX_SINGLE: assert property (done && !scan_bit && !repeat_bit
        |=> !conv_busy_flag && conv_end_flag && conv_end_irq_out)
        else $error("fixed single did not finish correctly");
    AST_SCAN_STEP: assert property (done && scan_bit && !scan_end
        |=> conv_busy_flag && !conv_end_irq_out && core_channel_out == $past(core_channel_out) + 3'h1)
        else $error("scan did not step to the next channel");
    AST_FIX_REP: assert property (done && fix_rep && !halt |=> conv_busy_flag && conv_end_flag)
        else $error("fixed repeat dropped busy or end flag");
    AST_ITM_SKIP: assert property (done && rot_mode && rot != `ADCS_ROT_LAST |=> !conv_end_irq_out)
        else $error("interrupt raised before fourth conversion");
    AST_HALT_STOP: assert property ((state == ADCS_CONV) && halt |=> !core_active_out)
        else $error("conversion continued into a halt");
    AST_STORE_FLAG: assert property (done |=> result_stored_flag[$past(store_idx)])
        else $error("stored flag not set after a result");
    AST_READ_CLEAR: assert property (rd_res && !group_end && !(done && fix_rep) |=> !conv_end_flag)
        else $error("result read did not clear end flag");

    // ------------------------------------------------------------------
    // Start and busy
    // ------------------------------------------------------------------
    AST_TRIG_START: assert property ((state == ADCS_IDLE) && ext_trigger_enable && trig_fall
        && !halt |=> core_start_out && conv_busy_flag)
        else $error("enabled trigger edge did not start a conversion");
    AST_BUSY_HELD: assert property ((state == ADCS_CONV) && !halt && !done
        |=> conv_busy_flag && core_active_out)
        else $error("busy dropped in the middle of a conversion");
    AST_CORE_ACTIVE: assert property (core_start_out
        |-> core_active_out)
        else $error("core start pulse outside an active conversion");
    AST_CONV_COUNT: assert property ((state == ADCS_CONV)
        |-> cnt <= `ADCS_CONV_LAST)
        else $error("conversion counter ran past its last state");

    // ------------------------------------------------------------------
    // Completion and interrupt
    // ------------------------------------------------------------------
    AST_SCAN_LAST: assert property (done && scan_end && !repeat_bit
        |=> !conv_busy_flag && conv_end_flag && conv_end_irq_out)
        else $error("single scan did not finish correctly");
    AST_EVERY_CONV: assert property (done && fix_rep && !irq_timing_bit
        |=> conv_end_irq_out)
        else $error("fixed repeat missed an interrupt");
    AST_SCAN_REP: assert property (done && scan_end && repeat_bit
        |=> conv_busy_flag && conv_end_irq_out && core_start_out && core_channel_out == 3'h0)
        else $error("scan repeat did not restart from channel zero");
    AST_IRQ_PULSE: assert property (conv_end_irq_out
        |=> !conv_end_irq_out)
        else $error("end interrupt lasted more than one cycle");
    AST_IRQ_EOC: assert property (conv_end_irq_out
        |-> conv_end_flag)
        else $error("end interrupt without end flag");
    AST_REPEAT_EXIT: assert property (done && !repeat_bit && !scan_bit
        |=> !conv_busy_flag)
        else $error("busy stayed set after the last conversion");

    // ------------------------------------------------------------------
    // Halt and restart
    // ------------------------------------------------------------------
    AST_HALT_NO_START: assert property ((state != ADCS_CONV) && halt
        |=> !core_start_out)
        else $error("conversion started during a halt");
    AST_SINGLE_HALT: assert property ((state == ADCS_CONV) && halt && !repeat_bit
        |=> !conv_busy_flag)
        else $error("single mode kept busy after a halt");
    AST_REP_RESTART: assert property ((state == ADCS_HOLD) && repeat_bit && !halt
        |=> core_start_out && cnt == 8'h00 && rot == 2'h0)
        else $error("repeat mode did not restart from the beginning");

    // ------------------------------------------------------------------
    // Result store and channel choice
    // ------------------------------------------------------------------
    AST_ROT_STEP: assert property (done && rot_mode
        |=> rot == $past(rot) + 2'h1)
        else $error("result rotation did not advance");
    AST_FIXED_STORE: assert property (done && !rot_mode
        |=> result_stored_flag[$past(core_channel_out)])
        else $error("result not stored in the pair of its input");
    AST_PAIR_CLEAR: assert property (rd_res && !done
        |=> !result_stored_flag[$past(rd_idx)])
        else $error("read did not clear the stored flag");
    AST_SCAN_FIRST: assert property (entering && scan_now
        |=> core_channel_out == 3'h0)
        else $error("scan did not begin at input zero");
    AST_CH_FIXED: assert property (entering && !scan_now
        |=> core_channel_out == $past(last_ch))
        else $error("fixed mode converted the wrong input");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------
    COV_FIX_SINGLE: cover property (done && !scan_bit && !repeat_bit);
    COV_SCAN_REPEAT: cover property (group_end && scan_bit && repeat_bit);
    COV_ROT_IRQ: cover property (irq_ev && rot_mode);
    COV_HALT_RESTART: cover property (state == ADCS_HOLD ##1 state == ADCS_CONV);
    COV_TRIG_START: cover property (start_req && !sw_start_bit);
endmodule

`default_nettype wire

// [bench/adcs_core_model.sv]
/*
 Behavioural analog core for the converter sequencer bench.
 Assumes the sequencer samples the result only inside a conversion.
*/
`timescale 1ns/10ps
`default_nettype none
module adcs_core_model (
    // Clock
    input wire logic clk_in,
    // Sequencer side
    input wire logic core_start_in,
    input wire logic core_active_in,
    input wire logic [2:0] core_channel_in,
    output adcs_pkg::adcs_result_t core_result_out
);
    import adcs_pkg::*;
    adcs_result_t churn = 10'h2aa;
    logic [2:0] ch_lat = 3'h0;
    // Outside a conversion the lines churn, so a stale sample cannot pass.
    // The channel is latched on the start pulse, so a missing pulse gives a wrong result.
    always @(posedge clk_in) begin
        churn <= ~churn;
        if (core_start_in) begin
            ch_lat <= core_channel_in;
        end
    end
    assign core_result_out = core_active_in ? {ch_lat, 7'h35} : churn;
endmodule
`default_nettype wire

// [bench/test_adcs_ctrl.sv]
/*
 Self-checking bench for the converter sequencer.
 Assumes the core model; the APB master waits for pready at rising edges.
*/
`timescale 1ns/10ps
`default_nettype none
module test_adcs_ctrl;
    import adcs_pkg::*;
    logic clk_in, rst_in, psel, pen, pwr, pin, hs, h1, h2, rdy, err, e, cs, ca, irq;
    logic [7:0] pa;
    logic [31:0] pwd, prd, q;
    logic [2:0] ch;
    adcs_result_t res;
    int miscompares, total_checks, n, t0, k;
    int cyc = 0;
    adcs_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
        .pslverr_out(err), .ext_trigger_pin_in(pin), .halt_stop_in(hs), .halt_idle_one_in(h1),
        .halt_idle_two_in(h2), .core_result_in(res), .core_start_out(cs),
        .core_active_out(ca), .core_channel_out(ch), .conv_end_irq_out(irq));
    adcs_core_model core (.clk_in(clk_in), .core_start_in(cs), .core_active_in(ca),
        .core_channel_in(ch), .core_result_out(res));
    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Holds the request until pready is sampled high at a rising edge, takes the
    // answer at that edge and only then releases; returns at the completing edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int j;
        j = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        do begin
            @(posedge clk_in);
            j++;
        end while (rdy !== 1'b1 && j < 20);
        if (j >= 20) miscompares++;
        q = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, q, exp);
    endtask
    task automatic go(input logic [31:0] chan, input logic [31:0] mode);
        apb(1'b1, 8'h04, chan);
        apb(1'b1, 8'h00, mode);
        t0 = cyc;
    endtask
    task automatic wait_irq(input int lim);
        do begin
            @(posedge clk_in);
        end while (irq !== 1'b1 && cyc - t0 < lim);
        n = cyc - t0;
    endtask
    function automatic logic [31:0] hi(input logic [2:0] c);
        return {24'h0, c, 5'h0d};
    endfunction
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_single;
        rd("mode0 reset", 8'h00, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        check("unmapped err", e, 1);
        go(3, 32'h01);
        wait_irq(300);
        check("single time", n, 133);
        rd("single end", 8'h00, 32'h80);
        rd("lo3", 8'h28, 32'h41);
        rd("end cleared", 8'h00, 32'h0);
        rd("lo3 again", 8'h28, 32'h40);
        apb(1'b1, 8'h2c, 32'hff);
        rd("hi3 kept", 8'h2c, hi(3));
    endtask
    task automatic t_trigger;
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h04, 32'h4);
        pin <= 1'b0;
        @(posedge clk_in);
        t0 = cyc;
        rd("busy", 8'h00, 32'h40);
        repeat (30) @(posedge clk_in);
        pin <= 1'b1;
        @(posedge clk_in);
        pin <= 1'b0;
        wait_irq(300);
        check("trigger time", n, 133);
        t0 = cyc;
        wait_irq(300);
        check("retrigger", irq, 0);
        pin <= 1'b1;
        rd("hi4", 8'h34, hi(4));
    endtask
    task automatic t_scan;
        go(2, 32'h03);
        wait_irq(600);
        check("scan time", n, 397);
        rd("scan end", 8'h00, 32'h82);
        for (k = 0; k < 3; k++) rd("scan pair", 8'h14 + 8 * k, hi(k));
    endtask
    task automatic t_repeat;
        go(1, 32'h0d);
        wait_irq(700);
        check("fourth first", n, 529);
        t0 = cyc;
        wait_irq(700);
        check("fourth next", n, 528);
        rd("repeat flags", 8'h00, 32'hcc);
        for (k = 0; k < 4; k++) rd("rotation", 8'h10 + 8 * k, 32'h41);
        apb(1'b1, 8'h00, 32'h08);
        repeat (140) @(posedge clk_in);
        apb(1'b0, 8'h00, 32'h0);
        check("repeat stop", q[6], 0);
        go(1, 32'h07);
        wait_irq(300);
        check("scan rep first", n, 265);
        t0 = cyc;
        wait_irq(300);
        check("scan rep next", n, 264);
        apb(1'b1, 8'h00, 32'h0);
        repeat (300) @(posedge clk_in);
    endtask
    task automatic t_halt;
        go(0, 32'h05);
        wait_irq(300);
        t0 = cyc;
        wait_irq(300);
        check("every conv", n, 132);
        repeat (50) @(posedge clk_in);
        h2 <= 1'b1;
        repeat (3) @(posedge clk_in);
        check("halt abort", ca, 0);
        repeat (20) @(posedge clk_in);
        h2 <= 1'b0;
        t0 = cyc;
        wait_irq(300);
        check("restart", n, 134);
        h1 <= 1'b1;
        repeat (3) @(posedge clk_in);
        check("idle one abort", ca, 0);
        h1 <= 1'b0;
        apb(1'b1, 8'h00, 32'h0);
        repeat (150) @(posedge clk_in);
        apb(1'b1, 8'h00, 32'h1);
        repeat (30) @(posedge clk_in);
        hs <= 1'b1;
        repeat (5) @(posedge clk_in);
        hs <= 1'b0;
        t0 = cyc;
        wait_irq(300);
        check("single stays", irq, 0);
        apb(1'b0, 8'h00, 32'h0);
        check("single idle", q[6], 0);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, pen, pwr, pa, pwd, hs, h1, h2} = '0;
        pin = 1'b1;
        rst_in = 1'b1;
        miscompares = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_single;
        t_trigger;
        t_scan;
        t_repeat;
        t_halt;
        close_out();
    end
endmodule
`default_nettype wire
